// ---- logic/pt1sf_pkg.sv ----
// Constants, register map and types for the PT1 smoothing filter bank.
// Assumes a single 50 MHz system clock and an AXI4-Lite register slave.
package pt1sf_pkg;

  localparam int NUM_CH = 32;
  localparam int ADDR_W = 12;

  // Global register byte offsets
  localparam logic [11:0] OFS_ENABLE = 12'h000;
  localparam logic [11:0] OFS_EVAL = 12'h004;
  localparam logic [11:0] OFS_CYCLE = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00C;
  localparam logic [11:0] OFS_CLR = 12'h010;
  localparam logic [11:0] OFS_IRQEN = 12'h014;
  localparam logic [11:0] OFS_CARRY = 12'h018;

  // Channel window: base + channel * 0x10, word field in addr[3:2]
  localparam logic [2:0] CHAN_REGION = 3'h1;
  localparam logic [1:0] FLD_INPUT = 2'h0;
  localparam logic [1:0] FLD_GAIN = 2'h1;
  localparam logic [1:0] FLD_RECOV = 2'h2;
  localparam logic [1:0] FLD_OUTPUT = 2'h3;

  // Reset values
  localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_EVAL = 32'hFFFF_FFFF;
  localparam logic [15:0] RST_CYCLE = 16'h0001;
  localparam logic [31:0] RST_IRQEN = 32'h0000_0000;

  // Timing
  localparam int unsigned SYS_CLK_HZ = 32'h02FA_F080;
  localparam int unsigned MS_PER_S = 32'h0000_03E8;
  localparam int unsigned CLKS_PER_MS = SYS_CLK_HZ / MS_PER_S;

  // Filter scaling
  localparam int GAIN_UNITY = 32'h0000_0064;
  localparam int TG_UNIT_MS = 32'h0000_0064;
  localparam int SCAN_KNEE_MS = 32'h0000_03E8;
  localparam int SCAN_MIN_MS = 32'h0000_000A;
  localparam int SCAN_DIV = 32'h0000_0064;
  localparam int OUT_MAX = 32'h0000_7FFF;
  localparam int OUT_MIN = -32'sh0000_8000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic signed [15:0] x;
    logic [15:0] kp;
    logic [15:0] tg;
  } pt1sf_chan_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } pt1sf_state_t;

endpackage

// ---- logic/pt1sf_top.sv ----
// Bank of PT1 smoothing filters behind an AXI4-Lite register slave.
// Assumes one 50 MHz clock, asynchronous active-low reset, software operands.
// Operation
// - Thirty-two independent filter channels
// - Enable low holds reset, output zero
// - Gain in percent, 100 means one
// - First evaluation loads output with input
// - Recovery time counted in tenths of second
// - Scan 10 ms up to 1 s, else Tg/100
// - Output step: ratio, gain, input minus output
// - Updates only at whole program cycles
// - Output signed 16-bit, carry when outside
// - Step response reaches 0.63 after Tg
// - Option decides whether enable is evaluated
//
// Chosen here: the AXI4-Lite register port and the address map.
module pt1sf_top #(
  parameter int unsigned CLKS_PER_MS = pt1sf_pkg::CLKS_PER_MS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // AXI4-Lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Interrupt
  output logic irq
);

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Returns {overflow, clamped value}
  function automatic logic [16:0] sat16(input logic signed [55:0] v);
    logic [16:0] r;
    r = {1'b0, v[15:0]};
    if (v > 56'(pt1sf_pkg::OUT_MAX)) begin
      r = {1'b1, 16'h7FFF};
    end else if (v < 56'(pt1sf_pkg::OUT_MIN)) begin
      r = {1'b1, 16'h8000};
    end
    return r;
  endfunction

  // Register state
  logic [31:0] enable_q;
  logic [31:0] eval_q;
  logic [15:0] cycle_q;
  logic [31:0] irqen_q;
  logic [31:0] stat_q;
  logic [31:0] carry_q;
  pt1sf_pkg::pt1sf_chan_t prm_q [pt1sf_pkg::NUM_CH];

  // Filter state per channel
  logic signed [15:0] y_q [pt1sf_pkg::NUM_CH];
  logic [17:0] el_q [pt1sf_pkg::NUM_CH];
  logic [31:0] first_q;

  // Bus state
  logic aw_have_q;
  logic w_have_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // Engine
  pt1sf_pkg::pt1sf_state_t state_q;
  logic [4:0] idx_q;
  logic [31:0] cyc_cnt_q;

  // ---------------- Write decode ----------------
  wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  wire wr_chan = aw_addr_q[11:9] == pt1sf_pkg::CHAN_REGION;
  wire [4:0] wr_ch = aw_addr_q[8:4];
  wire [1:0] wr_fld = aw_addr_q[3:2];
  wire [11:0] wr_word = {aw_addr_q[11:2], 2'b00};
  wire wr_glob_ok = wr_word == pt1sf_pkg::OFS_ENABLE || wr_word == pt1sf_pkg::OFS_EVAL ||
                    wr_word == pt1sf_pkg::OFS_CYCLE || wr_word == pt1sf_pkg::OFS_CLR ||
                    wr_word == pt1sf_pkg::OFS_IRQEN;
  // Output field is read-only, a write there is refused
  wire wr_ok = wr_chan ? (wr_fld != pt1sf_pkg::FLD_OUTPUT) : wr_glob_ok;
  // Low half of the addressed 16-bit field, merged with the byte strobes
  wire pt1sf_pkg::pt1sf_chan_t wr_prm = prm_q[wr_ch];
  wire [15:0] wr_old16 = !wr_chan ? cycle_q :
                         (wr_fld == pt1sf_pkg::FLD_GAIN) ? wr_prm.kp :
                         (wr_fld == pt1sf_pkg::FLD_RECOV) ? wr_prm.tg : wr_prm.x;
  wire [31:0] wr_merged = strb_merge({16'h0000, wr_old16}, w_data_q, w_strb_q);
  wire [31:0] clr_vec = (wr_fire && wr_word == pt1sf_pkg::OFS_CLR) ?
                        strb_merge(32'h0000_0000, w_data_q, w_strb_q) : 32'h0000_0000;

  // ---------------- Read decode ----------------
  wire rd_chan = s_axi_araddr[11:9] == pt1sf_pkg::CHAN_REGION;
  wire [4:0] rd_ch = s_axi_araddr[8:4];
  wire [11:0] rd_word = {s_axi_araddr[11:2], 2'b00};
  wire pt1sf_pkg::pt1sf_chan_t rd_prm = prm_q[rd_ch];
  wire [15:0] rd_y = y_q[rd_ch];
  logic [31:0] rd_data;
  logic rd_ok;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    if (rd_chan) begin
      unique case (s_axi_araddr[3:2])
        pt1sf_pkg::FLD_INPUT: rd_data = {{16{rd_prm.x[15]}}, rd_prm.x};
        pt1sf_pkg::FLD_GAIN: rd_data = {16'h0000, rd_prm.kp};
        pt1sf_pkg::FLD_RECOV: rd_data = {16'h0000, rd_prm.tg};
        pt1sf_pkg::FLD_OUTPUT: rd_data = {{16{rd_y[15]}}, rd_y};
      endcase
    end else begin
      unique case (rd_word)
        pt1sf_pkg::OFS_ENABLE: rd_data = enable_q;
        pt1sf_pkg::OFS_EVAL: rd_data = eval_q;
        pt1sf_pkg::OFS_CYCLE: rd_data = {16'h0000, cycle_q};
        pt1sf_pkg::OFS_STAT: rd_data = stat_q;
        pt1sf_pkg::OFS_CLR: rd_data = 32'h0000_0000;
        pt1sf_pkg::OFS_IRQEN: rd_data = irqen_q;
        pt1sf_pkg::OFS_CARRY: rd_data = carry_q;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // ---------------- AXI handshakes ----------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pt1sf_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? pt1sf_pkg::RESP_OKAY : pt1sf_pkg::RESP_SLVERR;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pt1sf_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? pt1sf_pkg::RESP_OKAY : pt1sf_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- Configuration registers ----------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= pt1sf_pkg::RST_ENABLE;
      eval_q <= pt1sf_pkg::RST_EVAL;
      cycle_q <= pt1sf_pkg::RST_CYCLE;
      irqen_q <= pt1sf_pkg::RST_IRQEN;
      for (int i = 0; i < pt1sf_pkg::NUM_CH; i++) begin
        prm_q[i] <= '0;
      end
    end else if (wr_fire && wr_ok) begin
      if (wr_chan) begin
        unique case (wr_fld)
          pt1sf_pkg::FLD_INPUT:
            prm_q[wr_ch].x <= wr_merged[15:0];
          pt1sf_pkg::FLD_GAIN:
            prm_q[wr_ch].kp <= wr_merged[15:0];
          pt1sf_pkg::FLD_RECOV:
            prm_q[wr_ch].tg <= wr_merged[15:0];
          pt1sf_pkg::FLD_OUTPUT: ;
        endcase
      end else begin
        unique case (wr_word)
          pt1sf_pkg::OFS_ENABLE: enable_q <= strb_merge(enable_q, w_data_q, w_strb_q);
          pt1sf_pkg::OFS_EVAL: eval_q <= strb_merge(eval_q, w_data_q, w_strb_q);
          pt1sf_pkg::OFS_CYCLE:
            cycle_q <= wr_merged[15:0];
          pt1sf_pkg::OFS_IRQEN: irqen_q <= strb_merge(irqen_q, w_data_q, w_strb_q);
          default: ;
        endcase
      end
    end
  end

  // ---------------- Program cycle timer ----------------
  // A zero cycle setting would stall every filter, so it counts as 1 ms
  wire [15:0] cycle_ms = (cycle_q == 16'h0000) ? 16'h0001 : cycle_q;
  wire [31:0] cyc_period = 32'(cycle_ms * CLKS_PER_MS);
  wire cyc_tick = cyc_cnt_q >= cyc_period - 32'h0000_0001;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_cnt_q <= 32'h0000_0000;
    end else begin
      cyc_cnt_q <= cyc_tick ? 32'h0000_0000 : cyc_cnt_q + 32'h0000_0001;
    end
  end

  // ---------------- Filter arithmetic for channel idx_q ----------------
  wire pt1sf_pkg::pt1sf_chan_t cp = prm_q[idx_q];
  wire signed [15:0] y_cur = y_q[idx_q];
  // Option off means the block runs regardless of its enable bit
  wire act = !eval_q[idx_q] || enable_q[idx_q];
  // Program cycles elapsed since the last update, in ms
  wire [17:0] dt_sum = el_q[idx_q] + 18'(cycle_ms);
  // Tg in tenths of a second gives scan in ms
  wire [17:0] tg_ms_scan = 18'(cp.tg * pt1sf_pkg::TG_UNIT_MS / pt1sf_pkg::SCAN_DIV);
  wire tg_short = 32'(cp.tg) * pt1sf_pkg::TG_UNIT_MS <= pt1sf_pkg::SCAN_KNEE_MS;
  wire [17:0] scan_ms = tg_short ? 18'(pt1sf_pkg::SCAN_MIN_MS) : tg_ms_scan;
  wire due = dt_sum >= scan_ms;
  wire tg_zero = cp.tg == 16'h0000;
  wire signed [16:0] diff = {cp.x[15], cp.x} - {y_cur[15], y_cur};
  // Zero recovery time degenerates to a plain gain step
  wire [17:0] dt_eff = tg_zero ? 18'h0_0001 : dt_sum;
  wire signed [55:0] num = 56'($signed({1'b0, dt_eff})) * 56'($signed({1'b0, cp.kp}))
                           * 56'(diff);
  // Ratio Ta/Tg and percent gain share one divisor
  wire signed [55:0] den = tg_zero ? 56'(pt1sf_pkg::GAIN_UNITY) :
                           56'(cp.tg) * 56'(pt1sf_pkg::TG_UNIT_MS * pt1sf_pkg::GAIN_UNITY);
  // Truncating divide: tiny residues never close; accepted for area
  wire signed [55:0] quo = num / den;
  wire signed [55:0] sum = 56'(y_cur) + quo;
  wire [16:0] sat = sat16(sum);
  wire upd = state_q == pt1sf_pkg::ST_RUN && act && !first_q[idx_q] && due;
  wire [31:0] set_vec = (upd && sat[16]) ? (32'h0000_0001 << idx_q) : 32'h0000_0000;

  // ---------------- Engine sequencing ----------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pt1sf_pkg::ST_IDLE;
      idx_q <= 5'h00;
    end else begin
      unique case (state_q)
        pt1sf_pkg::ST_IDLE: begin
          if (cyc_tick) begin
            state_q <= pt1sf_pkg::ST_RUN;
            idx_q <= 5'h00;
          end
        end
        pt1sf_pkg::ST_RUN: begin
          idx_q <= idx_q + 5'h01;
          if (idx_q == 5'h1F) begin
            state_q <= pt1sf_pkg::ST_IDLE;
          end
        end
        default: state_q <= pt1sf_pkg::ST_IDLE;
      endcase
    end
  end

  // ---------------- Filter state update ----------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_q <= 32'hFFFF_FFFF;
      carry_q <= 32'h0000_0000;
      for (int i = 0; i < pt1sf_pkg::NUM_CH; i++) begin
        y_q[i] <= 16'h0000;
        el_q[i] <= 18'h0_0000;
      end
    end else if (state_q == pt1sf_pkg::ST_RUN) begin
      if (!act) begin
        y_q[idx_q] <= 16'h0000;
        first_q[idx_q] <= 1'b1;
        el_q[idx_q] <= 18'h0_0000;
        carry_q[idx_q] <= 1'b0;
      end else if (first_q[idx_q]) begin
        y_q[idx_q] <= cp.x;
        first_q[idx_q] <= 1'b0;
        el_q[idx_q] <= 18'h0_0000;
        carry_q[idx_q] <= 1'b0;
      end else if (due) begin
        y_q[idx_q] <= sat[15:0];
        carry_q[idx_q] <= sat[16];
        el_q[idx_q] <= 18'h0_0000;
      end else begin
        el_q[idx_q] <= dt_sum;
      end
    end
  end

  // ---------------- Interrupt status ----------------
  // New overflow in the clearing cycle survives the clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~clr_vec) | set_vec;
      irq <= |(stat_q & irqen_q);
    end
  end

endmodule

// ---- tb/pt1sf_host.sv ----
// Register-bus master standing in for the controlling program.
// Assumes the AXI4-Lite slave of pt1sf_top on the same clock.
module pt1sf_host (
  // Clock
  input wire logic sys_clk,
  // Write channels
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Read channels
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output logic [11:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 28'h000_0000;
    s_axi_wdata = 32'h0000_0000;
  end

  // Operands are always whole words with in-range low halves
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    logic b_done;
    {aw_done, w_done, b_done} = 3'h0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_done) begin
      @(posedge sys_clk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        b_done = 1'b1;
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar_done;
    logic r_done;
    {ar_done, r_done} = 2'h0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_done) begin
      @(posedge sys_clk);
      if (!ar_done && s_axi_arready) begin
        ar_done = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        r_done = 1'b1;
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask
endmodule

// ---- tb/pt1sf_props.sv ----
// Bus handshake and interrupt checks for the filter bank.
// Assumes binding to pt1sf_top; sees only its ports.
module pt1sf_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // Interrupt
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("read not answered next cycle");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write not answered in two cycles");
  write_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
    && s_axi_awready && s_axi_wready) else $error("write slot not freed");
  read_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
    && s_axi_arready) else $error("read slot not freed");
  err_data_zero_a: assert property (s_axi_rvalid && s_axi_rresp == pt1sf_pkg::RESP_SLVERR
    |-> s_axi_rdata == 32'h0000_0000) else $error("refused read carries data");
  reset_quiet_a: assert property ($rose(rst_n) |-> !irq && !s_axi_bvalid && !s_axi_rvalid
    && s_axi_awready && s_axi_arready) else $error("outputs not idle after reset");

  cover property (s_axi_bvalid && s_axi_bresp == pt1sf_pkg::RESP_SLVERR);
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule

bind pt1sf_top pt1sf_props u_props (.sys_clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq);

// ---- tb/test_pt1_smoothing_filter.sv ----
// Self-checking bench for the filter bank, driven over the register bus.
// Assumes a shortened millisecond of 40 clocks.
module test_pt1_smoothing_filter;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int miscompares = 0;
  int checked = 0;

  always #10 sys_clk = ~sys_clk;

  pt1sf_top #(.CLKS_PER_MS(40)) u_dut (.sys_clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq);
  pt1sf_host u_host (.sys_clk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp);

  function automatic logic [11:0] ca(input int n, input int f);
    return 12'h200 + 12'(n * 16 + f * 4);
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e,
                       input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    u_host.rd(a, d, r);
    chk(n, d, e);
    chk(n, {30'h0, r}, {30'h0, er});
  endtask

  task automatic wrchk(input string n, input logic [11:0] a, input logic [31:0] d,
                       input logic [1:0] er);
    logic [1:0] r;
    u_host.wr(a, d, r);
    chk(n, {30'h0, r}, {30'h0, er});
  endtask

  // Reads until the value moves, then compares the new value
  task automatic poll(input string n, input logic [11:0] a, input logic [31:0] old,
                      input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    int i;
    d = old;
    for (i = 0; i < 300 && d === old; i++) begin
      u_host.rd(a, d, r);
    end
    chk(n, d, e);
  endtask

  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdchk("enable", 12'h000, 32'h0000_0000, 2'h0);
    rdchk("eval", 12'h004, 32'hFFFF_FFFF, 2'h0);
    rdchk("cycle", 12'h008, 32'h0000_0001, 2'h0);
    rdchk("irq_en", 12'h014, 32'h0000_0000, 2'h0);
    rdchk("irq_clr", 12'h010, 32'h0000_0000, 2'h0);
    rdchk("unmapped", 12'h100, 32'h0000_0000, 2'h2);
    wrchk("stat_wr", 12'h00C, 32'h0000_0001, 2'h2);
    wrchk("out_wr", ca(0, 3), 32'h0000_0005, 2'h2);
    wrchk("cycle_wr", 12'h008, 32'h0000_0001, 2'h0);
    wrchk("in0", ca(0, 0), 32'h0000_03E8, 2'h0);
    wrchk("gain0", ca(0, 1), 32'h0000_0064, 2'h0);
    wrchk("tg0", ca(0, 2), 32'h0000_000A, 2'h0);
    wrchk("in1", ca(1, 0), 32'h0000_004D, 2'h0);
    wrchk("in31", ca(31, 0), 32'hFFFF_FF9C, 2'h0);
    wrchk("gain31", ca(31, 1), 32'h0000_FFFF, 2'h0);
    wrchk("eval_wr", 12'h004, 32'hFFFF_FFFD, 2'h0);
    wrchk("enable_wr", 12'h000, 32'h8000_0001, 2'h0);
    poll("ch0_first", ca(0, 3), 32'h0000_0000, 32'h0000_03E8);
    poll("ch1_free", ca(1, 3), 32'h0000_0000, 32'h0000_004D);
    poll("ch31_first", ca(31, 3), 32'h0000_0000, 32'hFFFF_FF9C);
    wrchk("in0_step", ca(0, 0), 32'h0000_07D0, 2'h0);
    poll("ch0_step", ca(0, 3), 32'h0000_03E8, 32'h0000_03F2);
    wrchk("in31_step", ca(31, 0), 32'h0000_7FFF, 2'h0);
    poll("ch31_sat", ca(31, 3), 32'hFFFF_FF9C, 32'h0000_7FFF);
    rdchk("carry", 12'h018, 32'h8000_0000, 2'h0);
    rdchk("stat", 12'h00C, 32'h8000_0000, 2'h0);
    chk("irq_masked", {31'h0, irq}, 32'h0000_0000);
    wrchk("irq_en_wr", 12'h014, 32'h8000_0000, 2'h0);
    rdchk("stat_held", 12'h00C, 32'h8000_0000, 2'h0);
    chk("irq_on", {31'h0, irq}, 32'h0000_0001);
    wrchk("enable_off", 12'h000, 32'h0000_0001, 2'h0);
    poll("ch31_off", ca(31, 3), 32'h0000_7FFF, 32'h0000_0000);
    rdchk("carry_off", 12'h018, 32'h0000_0000, 2'h0);
    wrchk("irq_clr_wr", 12'h010, 32'h8000_0000, 2'h0);
    rdchk("stat_clr", 12'h00C, 32'h0000_0000, 2'h0);
    chk("irq_off", {31'h0, irq}, 32'h0000_0000);
    // Long recovery: scan is Tg/100 = 20 ms, rounded up to 7 cycles of 3 ms
    wrchk("cycle3", 12'h008, 32'h0000_0003, 2'h0);
    wrchk("gain2", ca(2, 1), 32'h0000_0064, 2'h0);
    wrchk("tg2", ca(2, 2), 32'h0000_0014, 2'h0);
    wrchk("enable2", 12'h000, 32'h0000_0005, 2'h0);
    // First pass must load the zero input before the step arrives
    repeat (160) @(posedge sys_clk);
    wrchk("in2_step", ca(2, 0), 32'h0000_2710, 2'h0);
    poll("ch2_scan", ca(2, 3), 32'h0000_0000, 32'h0000_0069);
    summarize();
  end
endmodule
